// [verilog/sccg_regs.svh]
// register offsets, field layout, reset values of the card clock generator
// assumes byte offsets within the block's own address window
`ifndef SCCG_REGS_SVH
`define SCCG_REGS_SVH

`define SCCG_ADDR_W           8
`define SCCG_DATA_W           16
`define SCCG_DIV_OFFSET       8'h40
`define SCCG_CTRL_OFFSET      8'h44
`define SCCG_DIV_W            5
`define SCCG_DIV_RESET        5'h00
`define SCCG_CTRL_EN_BIT      0
`define SCCG_CTRL_RESET       1'h0

`endif

// [verilog/sccg_pkg.sv]
// types shared by the card clock generator files
// assumes nothing beyond a SystemVerilog compiler
package sccg_pkg;

  typedef enum logic [1:0] {
    SCCG_IDLE = 2'h1,
    SCCG_RUN  = 2'h2
  } sccg_state_t;

endpackage

// [verilog/sccg_phase_div.sv]
// phase divider: toggles the card clock every half_div source cycles
// assumes half_div_i is nonzero while enable_i is high
`timescale 1ns/1ps
`include "sccg_regs.svh"

module sccg_phase_div #(
  parameter int DIV_W = `SCCG_DIV_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // control
  input  wire logic             enable_i,
  input  wire logic [DIV_W-1:0] half_div_i,
  // output
  output logic                  card_clk_o
);

  sccg_pkg::sccg_state_t state;
  sccg_pkg::sccg_state_t next_state;
  logic [DIV_W-1:0]      count;
  logic [DIV_W-1:0]      next_count;
  logic [DIV_W-1:0]      phase_len;
  logic [DIV_W-1:0]      next_phase_len;
  logic                  next_card_clk;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_phase_len = phase_len;
    next_card_clk  = card_clk_o;
    case (state)
      sccg_pkg::SCCG_IDLE: begin
        // disabled: output low, counter held in reset [RQ6]
        next_count    = '0;
        next_card_clk = 1'b0;
        if (enable_i) begin
          next_state     = sccg_pkg::SCCG_RUN; // [RQ7]
          next_phase_len = half_div_i;
        end
      end
      sccg_pkg::SCCG_RUN: begin
        if (!enable_i) begin
          next_state    = sccg_pkg::SCCG_IDLE; // [RQ6]
          next_count    = '0;
          next_card_clk = 1'b0;
        end else if (count + 1'b1 >= phase_len) begin
          // phase boundary: toggle and only now take the new divider [RQ2] [RQ4] [RQ12]
          // the length is latched per phase, so a phase never mixes settings [RQ5] [RQ13]
          next_count     = '0;
          next_card_clk  = ~card_clk_o;
          next_phase_len = half_div_i;
        end else begin
          next_count = count + 1'b1;
        end
      end
      default: begin
        next_state    = sccg_pkg::SCCG_IDLE;
        next_count    = '0;
        next_card_clk = 1'b0;
      end
    endcase
  end

  // sourced from the peripheral bus clock only, no baud rate input [RQ1]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= sccg_pkg::SCCG_IDLE; // [RQ8]
      count      <= '0;
      phase_len  <= '0;
      card_clk_o <= 1'b0;
    end else begin
      state      <= next_state;
      count      <= next_count;
      phase_len  <= next_phase_len;
      card_clk_o <= next_card_clk;
    end
  end

endmodule

// [verilog/sccg_top.sv]
// What this block does
// RQ1 - card clock comes only from the peripheral bus clock, not the baud rate
// RQ2 - output divides the source clock by twice the 5-bit divider field
// RQ3 - software never writes a zero divider value
// RQ4 - divider one gives half, divider two a quarter of source frequency
// RQ5 - divider changes never make a phase shorter than old or new setting
// RQ6 - enable low stops the clock, output low, divider counter reset
// RQ7 - enable high runs the generator at the programmed divider
// RQ8 - reset clears both registers, generator disabled, output low
// RQ9 - software writes zero to unused upper register bits
// RQ10 - divider register read/write at 0x40, control register at 0x44
// RQ11 - generator output routable to the card clock pin in alternate mode
// RQ12 - every high and low phase lasts exactly the divider value in cycles
// RQ13 - a new divider value takes effect only at the end of a phase
//
// top of the card clock generator: register port plus phase divider
// assumes a single-cycle strobe master on clk_i, 200 MHz
`timescale 1ns/1ps
`include "sccg_regs.svh"

module sccg_top #(
  parameter int ADDR_W = `SCCG_ADDR_W,
  parameter int DATA_W = `SCCG_DATA_W,
  parameter int DIV_W  = `SCCG_DIV_W
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              write_i,
  input  wire logic              read_i,
  output logic      [DATA_W-1:0] rdata_o,
  // pin mux: high routes the generator to the card clock pin
  input  wire logic              alt_func_i,
  // card clock pin, open drain: enable low while driving low
  output logic                   card_clock_pin_o,
  output logic                   card_clock_pin_oe_n_o
);

  logic [DIV_W-1:0]  half_division_value;
  logic [DIV_W-1:0]  next_half_division_value;
  logic              clock_enable;
  logic              next_clock_enable;
  logic [DATA_W-1:0] next_rdata;
  logic              gen_clk;
  logic              next_pin;
  logic              next_pin_oe_n;

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                  input logic [DIV_W-1:0]  d,
                                                  input logic              e);
    logic [DATA_W-1:0] v;
    v = '0;
    // upper bits read as zero; unmapped offsets read zero [RQ9]
    if (a == `SCCG_DIV_OFFSET) begin
      v[DIV_W-1:0] = d; // [RQ10]
    end else if (a == `SCCG_CTRL_OFFSET) begin
      v[`SCCG_CTRL_EN_BIT] = e; // [RQ10]
    end
    return v;
  endfunction

  always_comb begin
    next_half_division_value = half_division_value;
    next_clock_enable        = clock_enable;
    next_rdata               = '0;
    if (write_i) begin
      // a zero divider is not guarded: software must not write it [RQ3]
      if (addr_i == `SCCG_DIV_OFFSET) begin
        next_half_division_value = wdata_i[DIV_W-1:0]; // [RQ10]
      end else if (addr_i == `SCCG_CTRL_OFFSET) begin
        next_clock_enable = wdata_i[`SCCG_CTRL_EN_BIT]; // [RQ10]
      end
    end
    if (read_i) begin
      next_rdata = read_mux(addr_i, half_division_value, clock_enable);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      half_division_value <= `SCCG_DIV_RESET; // [RQ8]
      clock_enable        <= `SCCG_CTRL_RESET; // [RQ8]
      rdata_o             <= '0;
    end else begin
      half_division_value <= next_half_division_value;
      clock_enable        <= next_clock_enable;
      rdata_o             <= next_rdata;
    end
  end

  sccg_phase_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .enable_i   (clock_enable),
    .half_div_i (half_division_value),
    .card_clk_o (gen_clk)
  );

  // pin stage costs one cycle of latency but keeps outputs registered
  always_comb begin
    next_pin      = 1'b1;
    next_pin_oe_n = 1'b1;
    if (alt_func_i) begin
      next_pin      = gen_clk; // [RQ11]
      next_pin_oe_n = gen_clk; // released high, pulled by the external resistor
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      card_clock_pin_o      <= 1'b0;
      card_clock_pin_oe_n_o <= 1'b1;
    end else begin
      card_clock_pin_o      <= next_pin;
      card_clock_pin_oe_n_o <= next_pin_oe_n;
    end
  end

endmodule

// [verif/sccg_monitor.sv]
// checker for the card clock generator top
// assumes bind to sccg_top; one clock domain
`timescale 1ns/1ps
module sccg_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // register port and pin
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [15:0] rdata_o,
  input wire logic        alt_func_i,
  input wire logic        card_clock_pin_o,
  input wire logic        card_clock_pin_oe_n_o
);
  logic [4:0] div;
  logic       en;
  logic [5:0] quiet;
  logic [5:0] stuck;
  // quiet saturates so a 31-cycle phase from before the last write has ended
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div <= '0;
      en <= 1'b0;
      quiet <= '0;
      stuck <= '0;
    end else begin
      if (write_i && addr_i == 8'h40)
        div <= wdata_i[4:0];
      if (write_i && addr_i == 8'h44)
        en <= wdata_i[0];
      quiet <= (write_i || !alt_func_i) ? 6'h00 : quiet + 6'(quiet != 6'h3f);
      stuck <= (en && quiet == 6'h3f && !$changed(card_clock_pin_o)) ? stuck + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_stop;
    write_i && addr_i == 8'h44 && !wdata_i[0] ##1 (alt_func_i && !write_i)[*4];
  endsequence
  a_stop_low: assert property (s_stop |-> !card_clock_pin_o) else $error("clock not stopped");
  a_rd_idle: assert property (!$past(read_i) |-> rdata_o == 16'h0000) else $error("read data not idle");
  a_pin_released: assert property ($past(!alt_func_i && !reset_i)
    |-> card_clock_pin_o && card_clock_pin_oe_n_o) else $error("pin not released");
  a_pin_pair: assert property ($past(!reset_i) |-> card_clock_pin_o == card_clock_pin_oe_n_o)
    else $error("pin and enable differ");
  a_reset_low: assert property ($fell(reset_i) |-> !card_clock_pin_o && card_clock_pin_oe_n_o)
    else $error("pin wrong after reset");
  a_half_rate: assert property (en && div == 5'h01 && quiet == 6'h3f |-> $changed(card_clock_pin_o))
    else $error("half rate wrong");
  a_quarter_rate: assert property (en && div == 5'h02 && quiet == 6'h3f
    |-> card_clock_pin_o != $past(card_clock_pin_o, 2)) else $error("quarter rate wrong");
  a_runs_on: assert property (stuck < 6'h28) else $error("clock stuck while enabled");
endmodule
bind sccg_top sccg_monitor u_mon (.*);

// [verif/sccg_card.sv]
// card side model: measures each phase of the card clock wire
// assumes the wire already resolves the open-drain pull-up
`timescale 1ns/1ps
module sccg_card (
  // source clock and card clock wire
  input  wire logic clk_i,
  input  wire logic sc_clk_i,
  // last completed phase length
  output int        phase_o,
  output logic      edge_o
);
  int   cnt;
  logic last;
  always_ff @(posedge clk_i) begin
    last <= sc_clk_i;
    edge_o <= sc_clk_i != last;
    cnt <= (sc_clk_i != last) ? 1 : cnt + 1;
    if (sc_clk_i != last)
      phase_o <= cnt;
  end
endmodule

// [verif/test_smart_card_clock_generator.sv]
// bench for sccg_top with a card model on the clock wire
// assumes a 200 MHz source clock and the plain strobe register port
`timescale 1ns/1ps
module test_smart_card_clock_generator;
  logic        clk_i, reset_i, write_i, read_i, alt_func_i, pin, oe_n, edge_s, run_m;
  logic [7:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  int          error_cnt, check_count, cyc, phase, div_m, prev;
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  sccg_top DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata_o), .alt_func_i(alt_func_i), .card_clock_pin_o(pin),
    .card_clock_pin_oe_n_o(oe_n));
  sccg_card u_card (.clk_i(clk_i), .sc_clk_i(oe_n ? 1'b1 : pin), .phase_o(phase), .edge_o(edge_s));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    write_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  // a phase seen mid-change may carry the old or the new length, never less
  always @(posedge clk_i) begin
    if (run_m && edge_s)
      chk(16'(phase == div_m || phase == prev), 16'h0001);
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    {reset_i, alt_func_i} = 2'b11;
    {write_i, read_i, run_m, addr_i, wdata_i} = '0;
    void'($urandom(72));
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h40, 16'h0000);
    rd(8'h44, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      prev = div_m;
      div_m = (i < 2) ? i + 1 : int'($urandom_range(31, 1));
      wr(8'h40, 16'(div_m));
      rd(8'h40, 16'(div_m));
      if (i == 0)
        wr(8'h44, 16'h0001);
      repeat (70 + 4 * div_m) @(posedge clk_i);
      chk(16'(phase), 16'(div_m));
      prev = div_m;
      run_m = 1'b1;
    end
    $display("test divider done");
    run_m = 1'b0;
    wr(8'h44, 16'h0000);
    repeat (8) @(posedge clk_i);
    #1 chk({14'h0, pin, oe_n}, 16'h0000);
    wr(8'h48, 16'hffff);
    rd(8'h48, 16'h0000);
    rd(8'h44, 16'h0000);
    $display("test stop done");
    // run again, then pull reset in mid-run: registers and pin must fall back
    wr(8'h44, 16'h0001);
    rd(8'h44, 16'h0001);
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({14'h0, pin, oe_n}, 16'h0001);
    @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h40, 16'h0000);
    rd(8'h44, 16'h0000);
    $display("test mid-run reset done");
    @(posedge clk_i);
    alt_func_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk({14'h0, pin, oe_n}, 16'h0003);
    $display("test stop and release done");
    print_verdict;
  end
endmodule
